// *** sfio_pkg.sv ***
package sfio_pkg;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 24;
  localparam int MODE_W = 8;

  // Opcodes understood by the phase sequencer; replace to match a command set.
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DOUT = 8'h3B;
  localparam logic [7:0] OP_QOUT = 8'h6B;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_SERASE = 8'h20;
  localparam logic [7:0] OP_BERASE = 8'hD8;
  localparam logic [7:0] OP_CERASE = 8'hC7;
  localparam logic [7:0] OP_CERASE2 = 8'h60;
  localparam logic [7:0] OP_WRSTAT = 8'h01;

  // Opcode length, address phase lengths and fixed latencies.
  localparam logic [3:0] OPC_LAST = 4'h7;
  localparam logic [3:0] OPC_FULL = 4'h8;
  localparam logic [5:0] AIN1_CYC = 6'h18;
  localparam logic [5:0] AIN2_CYC = 6'h10;
  localparam logic [5:0] AIN4_CYC = 6'h08;
  localparam logic [4:0] LAT_FAST = 5'h08;
  localparam logic [4:0] LAT_DOUT = 5'h08;
  localparam logic [4:0] LAT_DIO = 5'h00;
  localparam logic [4:0] LAT_NONE = 5'h00;
  localparam logic [2:0] MOD8_ZERO = 3'h0;

  // Output enable patterns per lane width; single data leaves on lane1.
  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [3:0] OE_W1 = 4'h2;
  localparam logic [3:0] OE_W2 = 4'h3;
  localparam logic [3:0] OE_W4 = 4'hF;

  typedef enum logic [1:0] {SFIO_W1, SFIO_W2, SFIO_W4} sfio_wid_t;
  typedef enum logic [2:0] {PH_OPC, PH_AIN, PH_LAT, PH_OUT, PH_SINK} sfio_ph_t;

  // Tells whether an opcode programs, erases or writes status.
  function automatic logic sfio_is_write(input logic [7:0] op);
    return (op == OP_PROG) || (op == OP_QPROG) || (op == OP_SERASE) ||
           (op == OP_BERASE) || (op == OP_CERASE) || (op == OP_CERASE2) ||
           (op == OP_WRSTAT);
  endfunction : sfio_is_write

  // Bits moved per clock for a lane width.
  function automatic logic [2:0] sfio_step(input sfio_wid_t w);
    case (w)
      SFIO_W1: return 3'h1;
      SFIO_W2: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction : sfio_step

  // Clocks in the address phase for a lane width.
  function automatic logic [5:0] sfio_ain_cyc(input sfio_wid_t w);
    case (w)
      SFIO_W1: return AIN1_CYC;
      SFIO_W2: return AIN2_CYC;
      default: return AIN4_CYC;
    endcase
  endfunction : sfio_ain_cyc

endpackage : sfio_pkg

// *** sfio_guard_if.sv ***
`timescale 1ns/1ps
// Carries the power-up write guard from the timer to the sequencer.
interface sfio_guard_if;
  logic write_ok;
  modport timer (output write_ok);
  modport user (input write_ok);
endinterface : sfio_guard_if

// *** sfio_puw_timer.sv ***
`timescale 1ns/1ps
module sfio_puw_timer #(
  parameter int CYCLES = 500000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  sfio_guard_if.timer guard
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic ok;
  } sfio_tmr_t;

  sfio_tmr_t t_r;
  sfio_tmr_t t_nxt;

  // Counts from reset; writes stay locked until the delay has run out.
  always_comb
  begin
    t_nxt = t_r;
    if (!t_r.ok)
    begin
      t_nxt.cnt = t_r.cnt + CW'(1);
      t_nxt.ok = (t_r.cnt == LAST);
    end
  end

  // Registers the timer state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      t_r <= '0;
    else
      t_r <= t_nxt;
  end

  assign guard.write_ok = t_r.ok;

  // The guard opens only after the full count.
  AST_PUW_OPEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(t_r.ok) |-> ($past(t_r.cnt) == LAST))
    else $error("Write guard opened early.");

  COV_PUW_DONE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(t_r.ok));

endmodule : sfio_puw_timer

// *** sfio_phase_fsm.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Memory leaves its output undriven during single-lane input phases.
// - Dual and quad output reads take address on lane0 only, data back wide.
// - Quad reads take latency from the latency field; others fixed by opcode.
// - Lane values during latency clocks are ignored by the memory.
// - During dual latency lanes 0 and 1 stay undriven.
// - During quad latency all four lanes stay undriven.
// - Single output ignores lane0 and write protect, shifts data on lane1.
// - Output continues until the host raises select, at every width.
// - Dual I/O address comes two bits a clock, then output with no latency.
// - After the last dual latency clock the dual output phase starts.
// - Dual reads return two bits a clock on lanes 0 and 1.
// - Quad I/O address comes four bits a clock, then latency or output.
// - Quad reads return four bits a clock on all lanes.
// - Quad enable disables pause and write protect and permits quad reads.
// - Write commands are rejected until the power-up delay has passed.
// - In deep sleep only the wake command acts; all else is dropped.
// - Writes execute only on a whole multiple of eight clocks, else dropped with a pulse on the drop output.
// - Opcode is taken MSB first on rising clock edges after select falls.
// - Without quad enable, low pause freezes the command and floats outputs.
// - With select high the interface idles and ignores its inputs.
module sfio_phase_fsm #(
  parameter int TPUW_NS = 10000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe_o,
  input wire logic quad_enable_bit_i,
  input wire logic [3:0] latency_count_field_i,
  input wire logic [7:0] rd_data_i,
  output logic [23:0] rd_addr_o,
  output logic cmd_exec_o,
  output logic cmd_drop_o,
  output logic [7:0] cmd_opcode_o,
  output logic deep_sleep_o,
  output logic write_ok_o
);

  localparam int PUW_CYC = (TPUW_NS + sfio_pkg::CLK_PERIOD_NS - 1) / sfio_pkg::CLK_PERIOD_NS;

  // Link-side state, clocked on the rising serial clock.
  typedef struct packed {
    sfio_pkg::sfio_ph_t ph;
    sfio_pkg::sfio_wid_t wid;
    sfio_pkg::sfio_wid_t owid;
    logic mode;
    logic [7:0] opc;
    logic [3:0] obits;
    logic [2:0] mod8;
    logic [31:0] sr;
    logic [5:0] cnt;
    logic [4:0] lat;
    logic [23:0] addr;
    logic [2:0] bpos;
    logic hold;
    logic qe_s1;
    logic qe_s2;
    logic [3:0] lt_s1;
    logic [3:0] lt_s2;
    logic dp_s1;
    logic dp_s2;
  } sfio_lnk_t;

  // Lane drivers, clocked on the falling serial clock.
  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] dat;
    logic [7:0] sh;
  } sfio_drv_t;

  // System-side state.
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_p;
    logic dsl;
    logic exec;
    logic drop;
    logic [7:0] opc;
  } sfio_sys_t;

  sfio_lnk_t l_r;
  sfio_lnk_t l_nxt;
  sfio_drv_t d_r;
  sfio_drv_t d_nxt;
  sfio_sys_t s_r;
  sfio_sys_t s_nxt;
  logic in_frame_r;
  logic pause;
  logic [7:0] opc_in;
  logic sys_rise;

  sfio_guard_if guard ();

  sfio_puw_timer #(
    .CYCLES(PUW_CYC)
  ) u_puw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .guard(guard)
  );

  // Pause is honoured only while quad mode is off.
  assign pause = !l_r.qe_s2 && !lane_i[3];
  assign opc_in = {l_r.opc[6:0], lane_i[0]};
  assign sys_rise = s_r.cs_s2 && !s_r.cs_p;

  // Marks the frame; select high clears it at once, so each frame restarts.
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      in_frame_r <= 1'b0;
    else
      in_frame_r <= 1'b1;
  end

  // Phase sequencing on rising serial clock edges.
  always_comb
  begin
    logic [2:0] nb;
    nb = 3'h0;
    l_nxt = l_r;
    l_nxt.hold = pause;
    l_nxt.qe_s1 = quad_enable_bit_i;
    l_nxt.qe_s2 = l_r.qe_s1;
    l_nxt.lt_s1 = latency_count_field_i;
    l_nxt.lt_s2 = l_r.lt_s1;
    l_nxt.dp_s1 = s_r.dsl;
    l_nxt.dp_s2 = l_r.dp_s1;
    if (!in_frame_r)
    begin
      // First edge of a frame carries the opcode MSB.
      l_nxt.ph = sfio_pkg::PH_OPC;
      l_nxt.opc = {7'h00, lane_i[0]};
      l_nxt.obits = 4'h1;
      l_nxt.mod8 = 3'h1;
      l_nxt.cnt = 6'h00;
      l_nxt.bpos = 3'h0;
      l_nxt.sr = 32'h0000_0000;
    end
    else if (!pause)
    begin
      l_nxt.mod8 = l_r.mod8 + 3'h1;
      case (l_r.ph)
        sfio_pkg::PH_OPC:
        begin
          l_nxt.opc = opc_in;
          l_nxt.obits = l_r.obits + 4'h1;
          if (l_r.obits == sfio_pkg::OPC_LAST)
          begin
            l_nxt.ph = sfio_pkg::PH_SINK;
            l_nxt.wid = sfio_pkg::SFIO_W1;
            l_nxt.owid = sfio_pkg::SFIO_W1;
            l_nxt.mode = 1'b0;
            l_nxt.lat = sfio_pkg::LAT_NONE;
            if (!l_r.dp_s2)
            begin
              case (opc_in)
                sfio_pkg::OP_READ: l_nxt.ph = sfio_pkg::PH_AIN;
                sfio_pkg::OP_FAST:
                begin
                  l_nxt.ph = sfio_pkg::PH_AIN;
                  l_nxt.lat = sfio_pkg::LAT_FAST;
                end
                sfio_pkg::OP_DOUT:
                begin
                  l_nxt.ph = sfio_pkg::PH_AIN;
                  l_nxt.owid = sfio_pkg::SFIO_W2;
                  l_nxt.lat = sfio_pkg::LAT_DOUT;
                end
                sfio_pkg::OP_DIO:
                begin
                  l_nxt.ph = sfio_pkg::PH_AIN;
                  l_nxt.wid = sfio_pkg::SFIO_W2;
                  l_nxt.owid = sfio_pkg::SFIO_W2;
                  l_nxt.mode = 1'b1;
                  l_nxt.lat = sfio_pkg::LAT_DIO;
                end
                sfio_pkg::OP_QOUT:
                begin
                  if (l_r.qe_s2)
                  begin
                    l_nxt.ph = sfio_pkg::PH_AIN;
                    l_nxt.owid = sfio_pkg::SFIO_W4;
                    l_nxt.lat = {1'b0, l_r.lt_s2};
                  end
                end
                sfio_pkg::OP_QIO:
                begin
                  if (l_r.qe_s2)
                  begin
                    l_nxt.ph = sfio_pkg::PH_AIN;
                    l_nxt.wid = sfio_pkg::SFIO_W4;
                    l_nxt.owid = sfio_pkg::SFIO_W4;
                    l_nxt.mode = 1'b1;
                    l_nxt.lat = {1'b0, l_r.lt_s2};
                  end
                end
                default: l_nxt.ph = sfio_pkg::PH_SINK;
              endcase
            end
          end
        end
        sfio_pkg::PH_AIN:
        begin
          // Address and mode bits, one, two or four per clock.
          case (l_r.wid)
            sfio_pkg::SFIO_W1: l_nxt.sr = {l_r.sr[30:0], lane_i[0]};
            sfio_pkg::SFIO_W2: l_nxt.sr = {l_r.sr[29:0], lane_i[1:0]};
            default: l_nxt.sr = {l_r.sr[27:0], lane_i};
          endcase
          l_nxt.cnt = l_r.cnt + 6'h01;
          if (l_r.cnt == sfio_pkg::sfio_ain_cyc(l_r.wid) - 6'h01)
          begin
            l_nxt.addr = l_r.mode ? l_nxt.sr[31:sfio_pkg::MODE_W] :
                         l_nxt.sr[sfio_pkg::ADDR_W-1:0];
            l_nxt.cnt = 6'h00;
            l_nxt.bpos = 3'h0;
            l_nxt.ph = (l_r.lat == sfio_pkg::LAT_NONE) ? sfio_pkg::PH_OUT :
                       sfio_pkg::PH_LAT;
          end
        end
        sfio_pkg::PH_LAT:
        begin
          // Lane values are not looked at here.
          l_nxt.cnt = l_r.cnt + 6'h01;
          if (l_r.cnt[4:0] == l_r.lat - 5'h01)
          begin
            l_nxt.cnt = 6'h00;
            l_nxt.ph = sfio_pkg::PH_OUT;
          end
        end
        sfio_pkg::PH_OUT:
        begin
          // Stays here until select rises; address walks on byte ends.
          nb = l_r.bpos + sfio_pkg::sfio_step(l_r.owid);
          l_nxt.bpos = nb;
          if (nb == 3'h0)
            l_nxt.addr = l_r.addr + 24'h00_0001;
        end
        sfio_pkg::PH_SINK: l_nxt.ph = sfio_pkg::PH_SINK;
        default: l_nxt.ph = sfio_pkg::PH_SINK;
      endcase
    end
  end

  // Registers link state; no reset, the first frame edge restarts it.
  always_ff @(posedge sck_i)
  begin
    l_r <= l_nxt;
  end

  // Lane drivers; only the output phase drives, never while paused.
  always_comb
  begin
    logic [7:0] byt;
    byt = d_r.sh;
    d_nxt = d_r;
    d_nxt.oe = sfio_pkg::OE_NONE;
    d_nxt.dat = 4'h0;
    if (in_frame_r && !l_r.hold && (l_r.ph == sfio_pkg::PH_OUT))
    begin
      byt = (l_r.bpos == 3'h0) ? rd_data_i : d_r.sh;
      case (l_r.owid)
        sfio_pkg::SFIO_W1:
        begin
          d_nxt.oe = sfio_pkg::OE_W1;
          d_nxt.dat = {2'h0, byt[7], 1'b0};
          d_nxt.sh = {byt[6:0], 1'b0};
        end
        sfio_pkg::SFIO_W2:
        begin
          d_nxt.oe = sfio_pkg::OE_W2;
          d_nxt.dat = {2'h0, byt[7:6]};
          d_nxt.sh = {byt[5:0], 2'h0};
        end
        default:
        begin
          d_nxt.oe = sfio_pkg::OE_W4;
          d_nxt.dat = byt[7:4];
          d_nxt.sh = {byt[3:0], 4'h0};
        end
      endcase
    end
  end

  // Launches data on falling edges; select high floats every lane.
  always_ff @(negedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      d_r <= '0;
    else
      d_r <= d_nxt;
  end

  // Command guards, judged when the synchronised select rises.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cs_s1 = cs_n_i;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.cs_p = s_r.cs_s2;
    s_nxt.exec = 1'b0;
    s_nxt.drop = 1'b0;
    if (sys_rise && (l_r.obits >= sfio_pkg::OPC_FULL))
    begin
      s_nxt.opc = l_r.opc;
      if (s_r.dsl)
      begin
        if (l_r.opc == sfio_pkg::OP_WAKE)
        begin
          s_nxt.dsl = 1'b0;
          s_nxt.exec = 1'b1;
        end
        else
          s_nxt.drop = 1'b1;
      end
      else if (l_r.opc == sfio_pkg::OP_SLEEP)
      begin
        s_nxt.dsl = 1'b1;
        s_nxt.exec = 1'b1;
      end
      else if (sfio_pkg::sfio_is_write(l_r.opc))
      begin
        if (guard.write_ok && (l_r.mod8 == sfio_pkg::MOD8_ZERO))
          s_nxt.exec = 1'b1;
        else
          s_nxt.drop = 1'b1;
      end
    end
  end

  // Registers system state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_p: 1'b1, default: '0};
    else
      s_r <= s_nxt;
  end

  assign lane_o = d_r.dat;
  assign lane_oe_o = d_r.oe;
  assign rd_addr_o = l_r.addr;
  assign cmd_exec_o = s_r.exec;
  assign cmd_drop_o = s_r.drop;
  assign cmd_opcode_o = s_r.opc;
  assign deep_sleep_o = s_r.dsl;
  assign write_ok_o = guard.write_ok;

  // Link-side checks.
  AST_AIN_QUIET: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && (l_r.ph == sfio_pkg::PH_AIN)) |-> (lane_oe_o == sfio_pkg::OE_NONE))
    else $error("Output driven during input phase.");
  AST_LAT_DUAL: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && (l_r.ph == sfio_pkg::PH_LAT) && (l_r.owid == sfio_pkg::SFIO_W2))
    |-> (lane_oe_o[1:0] == 2'h0))
    else $error("Lanes driven during dual latency.");
  AST_LAT_QUAD: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && (l_r.ph == sfio_pkg::PH_LAT) && (l_r.owid == sfio_pkg::SFIO_W4))
    |-> (lane_oe_o == sfio_pkg::OE_NONE))
    else $error("Lanes driven during quad latency.");
  AST_OUT_ONE: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && !l_r.hold && (l_r.ph == sfio_pkg::PH_OUT) &&
     (l_r.owid == sfio_pkg::SFIO_W1)) |-> (lane_oe_o == sfio_pkg::OE_W1))
    else $error("Single output not on lane1.");
  AST_OUT_DUAL: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && !l_r.hold && (l_r.ph == sfio_pkg::PH_OUT) &&
     (l_r.owid == sfio_pkg::SFIO_W2)) |-> (lane_oe_o == sfio_pkg::OE_W2))
    else $error("Dual output not on lanes 0 and 1.");
  AST_OUT_QUAD: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && !l_r.hold && (l_r.ph == sfio_pkg::PH_OUT) &&
     (l_r.owid == sfio_pkg::SFIO_W4)) |-> (lane_oe_o == sfio_pkg::OE_W4))
    else $error("Quad output not on all lanes.");
  AST_OUT_STAYS: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && (l_r.ph == sfio_pkg::PH_OUT)) |=> (l_r.ph == sfio_pkg::PH_OUT))
    else $error("Output phase left before select rose.");
  AST_DUAL_AFTER_LAT: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && !pause && (l_r.ph == sfio_pkg::PH_LAT) &&
     (l_r.owid == sfio_pkg::SFIO_W2) && (l_r.cnt[4:0] == l_r.lat - 5'h01))
    |=> (l_r.ph == sfio_pkg::PH_OUT))
    else $error("Dual output not entered after latency.");
  AST_QUAD_GATE: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && !pause && (l_r.ph == sfio_pkg::PH_OPC) && !l_r.qe_s2 &&
     (l_r.obits == sfio_pkg::OPC_LAST) &&
     ((opc_in == sfio_pkg::OP_QIO) || (opc_in == sfio_pkg::OP_QOUT)))
    |=> (l_r.ph == sfio_pkg::PH_SINK))
    else $error("Quad read accepted without quad enable.");
  AST_QLAT_FIELD: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && !pause && (l_r.ph == sfio_pkg::PH_OPC) && l_r.qe_s2 && !l_r.dp_s2 &&
     (l_r.obits == sfio_pkg::OPC_LAST) && (opc_in == sfio_pkg::OP_QIO))
    |=> (l_r.lat == {1'b0, $past(l_r.lt_s2)}))
    else $error("Quad latency not taken from the field.");
  AST_HOLD_FREEZE: assert property (@(posedge sck_i) disable iff (cs_n_i)
    (in_frame_r && pause) |=> ($stable(l_r.ph) && $stable(l_r.cnt) && $stable(l_r.bpos)))
    else $error("Command advanced while paused.");

  // System-side checks.
  AST_SLEEP_FILTER: assert property (@(posedge clk_i) disable iff (rst_i)
    (sys_rise && s_r.dsl && (l_r.opc != sfio_pkg::OP_WAKE)) |=> !cmd_exec_o)
    else $error("Command executed in deep sleep.");
  AST_WHOLE_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
    (sys_rise && !s_r.dsl && (l_r.obits >= sfio_pkg::OPC_FULL) &&
     sfio_pkg::sfio_is_write(l_r.opc) && (l_r.mod8 != sfio_pkg::MOD8_ZERO))
    |=> (cmd_drop_o && !cmd_exec_o))
    else $error("Write with partial byte executed.");
  AST_PUW_GUARD: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_exec_o && sfio_pkg::sfio_is_write(cmd_opcode_o)) |-> $past(write_ok_o))
    else $error("Write executed before power-up delay.");

  COV_QUAD_OUT: cover property (@(posedge sck_i) disable iff (cs_n_i)
    (l_r.ph == sfio_pkg::PH_OUT) && (l_r.owid == sfio_pkg::SFIO_W4));
  COV_DUAL_OUT: cover property (@(posedge sck_i) disable iff (cs_n_i)
    (l_r.ph == sfio_pkg::PH_OUT) && (l_r.owid == sfio_pkg::SFIO_W2));
  COV_EXEC: cover property (@(posedge clk_i) disable iff (rst_i) cmd_exec_o);
  COV_DROP: cover property (@(posedge clk_i) disable iff (rst_i) cmd_drop_o);

endmodule : sfio_phase_fsm

// *** sfio_host_model.sv ***
`timescale 1ns/1ps
// Host controller model: frames select, makes the serial clock only inside frames.
module sfio_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] lane_o,
  input wire logic [3:0] lane_i,
  input wire logic [3:0] oe_i
);
  // Idle state: select high, clock low, pause line high.
  // Select rises 1 ns in, so the link's asynchronous clear sees a definite edge.
  initial
  begin
    sck_o = 1'b0;
    lane_o = 4'h8;
    #1 cs_n_o = 1'b1;
  end

  // Set by the bench to insert one paused clock after the next opcode.
  bit pause_once;

  // One clock; released lanes show the inverse of their last value so stale data never passes.
  task automatic cyc(input logic [3:0] m, input logic [3:0] v, input logic q, input logic [3:0] eoe,
                     inout int bad, output logic [3:0] smp);
    lane_o = (v & m) | (~lane_o & ~m) | {!q, 3'h0};
    #7.5 sck_o = 1'b1;
    smp = lane_i;
    if (oe_i !== eoe) bad++;
    #7.5 sck_o = 1'b0;
  endtask : cyc

  // Whole frame: opcode, input phase, latency with lanes released, then output sampled on rise.
  task automatic xfer(input logic [7:0] op, input int wi, input logic [31:0] pay, input int ni,
                      input int nl, input int wo, input int no, input logic [3:0] eoe,
                      output logic [15:0] rx, output int bad);
    logic [3:0] s;
    logic [3:0] mo;
    bad = 0;
    rx = 16'h0000;
    mo = 4'((1 << wo) - 1);
    #7.5 cs_n_o = 1'b0;
    for (int i = 0; i < 8; i++) cyc(4'h1, {3'h0, op[7 - i]}, 1'b0, 4'h0, bad, s);
    // Optional paused clock: pause line low, every other lane released.
    if (pause_once) cyc(4'h8, 4'h0, 1'b1, 4'h0, bad, s);
    for (int i = 0; i < ni; i++)
    begin
      cyc(4'((1 << wi) - 1), pay[31 -: 4] >> (4 - wi), wi == 4, 4'h0, bad, s);
      pay = pay << wi;
    end
    for (int i = 0; i < nl; i++) cyc(4'h0, 4'h0, wo == 4, 4'h0, bad, s);
    for (int i = 0; i < no; i++)
    begin
      cyc(4'h0, 4'h0, wo == 4, eoe, bad, s);
      rx = (rx << wo) | ((wo == 1) ? {15'h0000, s[1]} : {12'h000, s & mo});
    end
    #7.5 cs_n_o = 1'b1;
  endtask : xfer
endmodule : sfio_host_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] WR [7] = '{sfio_pkg::OP_PROG, sfio_pkg::OP_QPROG, sfio_pkg::OP_SERASE,
    sfio_pkg::OP_BERASE, sfio_pkg::OP_CERASE, sfio_pkg::OP_CERASE2, sfio_pkg::OP_WRSTAT};
  logic clk_i;
  logic rst_i;
  logic qe;
  logic [3:0] lat_f;
  logic sck;
  logic cs_n;
  logic [3:0] hl;
  logic [3:0] wl;
  logic [3:0] dl;
  logic [3:0] doe;
  logic [23:0] ra;
  logic ex;
  logic dr;
  logic ds;
  logic wok;
  logic [7:0] op_s;
  int err_count;
  int comparisons;
  int n_ex;
  int n_dr;
  int cyc_n;
  bit sleep_m;
  bit wok_m;

  // Reference byte stored at each address.
  function automatic logic [7:0] dat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : dat

  // Wire level of each lane: memory drive where enabled, host drive elsewhere.
  assign wl = (doe & dl) | (~doe & hl);

  sfio_phase_fsm #(.TPUW_NS(2000)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck),
    .cs_n_i(cs_n), .lane_i(wl), .lane_o(dl), .lane_oe_o(doe), .quad_enable_bit_i(qe),
    .latency_count_field_i(lat_f), .rd_data_i(dat(ra)), .rd_addr_o(ra), .cmd_exec_o(ex),
    .cmd_drop_o(dr), .cmd_opcode_o(op_s), .deep_sleep_o(ds), .write_ok_o(wok));
  sfio_host_model host_u (.sck_o(sck), .cs_n_o(cs_n), .lane_o(hl), .lane_i(wl), .oe_i(doe));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Counts judgement pulses mid-cycle, away from their launching edge, and cuts a hang short.
  always @(negedge clk_i)
  begin
    cyc_n++;
    if (ex === 1'b1) n_ex++;
    if (dr === 1'b1) n_dr++;
    if (cyc_n == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // Counts one comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One frame against the reference model of judgement and read data.
  task automatic run(input logic [7:0] op, input int wi, input int ni, input int nl,
                     input int wo, input int no, input logic [3:0] eoe);
    logic [31:0] pay;
    logic [15:0] rx;
    int bad;
    int e0;
    int d0;
    bit e;
    bit d;
    logic [7:0] exp_q[$];
    pay = $urandom();
    e0 = n_ex;
    d0 = n_dr;
    e = 1'b0;
    d = 1'b0;
    if (sleep_m)
    begin
      e = (op == sfio_pkg::OP_WAKE);
      d = !e;
      sleep_m = !e;
    end
    else if (op inside {WR})
    begin
      e = wok_m && ((8 + ni + nl + no) % 8 == 0);
      d = !e;
    end
    else if (op == sfio_pkg::OP_SLEEP)
    begin
      e = 1'b1;
      sleep_m = 1'b1;
    end
    // Expected bytes, in the order in which they leave the memory.
    exp_q = {dat(pay[31:8]), dat(pay[31:8] + 24'h00_0001)};
    host_u.xfer(op, wi, pay, ni, nl, wo, no, eoe, rx, bad);
    repeat (8) @(posedge clk_i);
    chk("lane enables", 0, 32'(bad));
    if (eoe != 4'h0) chk("read data", {exp_q[0], exp_q[1]}, rx);
    if (e || d) chk("opcode", 32'(op), 32'(op_s));
    chk("exec", 32'(e), 32'(n_ex - e0));
    chk("drop", 32'(d), 32'(n_dr - d0));
    chk("idle enables", 0, doe);
    $display("test %h done", op);
  endtask : run

  // Reads at every width; latency counts follow opcode or the quad field.
  task automatic reads;
    run(sfio_pkg::OP_READ, 1, 24, 0, 1, 16, 4'h2);
    run(sfio_pkg::OP_FAST, 1, 24, 8, 1, 16, 4'h2);
    run(sfio_pkg::OP_DOUT, 1, 24, 8, 2, 8, 4'h3);
    run(sfio_pkg::OP_QOUT, 1, 24, lat_f, 4, 4, 4'hf);
    run(sfio_pkg::OP_DIO, 2, 16, 0, 2, 8, 4'h3);
    run(sfio_pkg::OP_QIO, 4, 8, lat_f, 4, 4, 4'hf);
  endtask : reads

  task automatic end_of_test;
    $display("Mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial
  begin
    rst_i = 1'b1;
    qe = 1'b1;
    lat_f = 4'h0;
    void'($urandom(32'hc956_1a3a));
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    chk("write guard", 0, 32'(wok));
    run(sfio_pkg::OP_SERASE, 1, 24, 0, 1, 0, 4'h0);
    repeat (100) @(posedge clk_i);
    chk("write guard", 1, 32'(wok));
    wok_m = 1'b1;
    // Whole and partial byte clock counts for every write opcode.
    foreach (WR[i])
      for (int p = 0; p < 2; p++) run(WR[i], 1, 8 * $urandom_range(4, 0) + p * $urandom_range(7, 1),
        0, 1, 0, 4'h0);
    for (int f = 0; f < 2; f++)
    begin
      #1 lat_f = (f == 0) ? 4'($urandom_range(15, 1)) : 4'h0;
      repeat (4) @(posedge clk_i);
      reads();
    end
    #1 qe = 1'b0;
    repeat (4) @(posedge clk_i);
    // One paused clock in the address phase must not shift the address.
    host_u.pause_once = 1'b1;
    run(sfio_pkg::OP_READ, 1, 24, 0, 1, 16, 4'h2);
    host_u.pause_once = 1'b0;
    run(sfio_pkg::OP_QOUT, 1, 24, 4, 1, 8, 4'h0);
    run(sfio_pkg::OP_QIO, 1, 8, 4, 1, 8, 4'h0);
    run(sfio_pkg::OP_SLEEP, 1, 0, 0, 1, 0, 4'h0);
    chk("deep sleep", 1, 32'(ds));
    run(sfio_pkg::OP_READ, 1, 24, 0, 1, 16, 4'h0);
    run(sfio_pkg::OP_PROG, 1, 32, 0, 1, 0, 4'h0);
    run(sfio_pkg::OP_WAKE, 1, 0, 0, 1, 0, 4'h0);
    chk("deep sleep", 0, 32'(ds));
    end_of_test();
  end
endmodule : tb_top
